// *** rtl/flash_host_pkg.sv ***
`default_nettype none
package flash_host_pkg;
	// flash word address and data widths
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	// sector map: 64 Kword sectors, index above the low sixteen bits
	localparam int SECTOR_OFS_W = 16;
	localparam int SECTOR_COUNT = 1024;
	localparam int SECTOR_W = ADDR_W - SECTOR_OFS_W;
	localparam logic [SECTOR_W-1:0] LAST_SECTOR = SECTOR_W'(SECTOR_COUNT - 1);
	// byte-mode lane layout
	localparam int LSB_LINE = 15;
	localparam logic [DATA_W-1:0] OE_WORD = 16'hFFFF;
	localparam logic [DATA_W-1:0] OE_BYTE_WR = 16'h80FF;
	localparam logic [DATA_W-1:0] OE_BYTE_RD = 16'h8000;
	localparam logic [DATA_W-1:0] OE_NONE = 16'h0000;
	// timing in ns, turned into cycles of CLK_SYS
	localparam int CLK_PERIOD_NS = 40;
	localparam int ACC_TIME_NS = 100;
	localparam int OE_TIME_NS = 25;
	localparam int WE_PULSE_NS = 50;
	localparam int WR_HOLD_NS = 40;
	localparam int CE_GAP_NS = 40;
	localparam int RESET_PULSE_NS = 500;
	localparam int RESET_RECOVER_NS = 1000;
	localparam int SYNC_STAGES = 2;
	localparam int TMR_W = 8;
	localparam int ACC_CYC = (ACC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OE_CYC = (OE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MAX_ACC_CYC = (ACC_CYC > OE_CYC) ? ACC_CYC : OE_CYC;
	localparam logic [TMR_W-1:0] READ_WAIT_CYC =
		TMR_W'(MAX_ACC_CYC + SYNC_STAGES);
	localparam logic [TMR_W-1:0] WE_PULSE_CYC =
		TMR_W'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] WR_HOLD_CYC =
		TMR_W'((WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] CE_GAP_CYC =
		TMR_W'((CE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] RESET_PULSE_CYC =
		TMR_W'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] RESET_RECOVER_CYC =
		TMR_W'((RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// controller states
	typedef enum logic [3:0] {
		ST_BOOT,
		ST_RESET_PULSE,
		ST_RESET_WAIT,
		ST_IDLE,
		ST_SETUP,
		ST_READ,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_GAP
	} state_t;
endpackage
`default_nettype wire

// *** rtl/cycle_timer.sv ***
`default_nettype none
module cycle_timer (
	input wire logic clk, // system clock
	input wire logic rst_n, // sync reset, active low
	input wire logic en, // clock enable
	input wire logic load, // load a new count
	input wire logic [flash_host_pkg::TMR_W-1:0] value, // cycles to wait
	output logic expired // count has run out
);
	import flash_host_pkg::*;

	logic [TMR_W-1:0] cnt_r;
	logic [TMR_W-1:0] cnt_nxt;

	// load or count down to zero and stop
	always_comb begin
		cnt_nxt = cnt_r;
		if (load) begin
			cnt_nxt = value;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - TMR_W'(1);
		end
	end

	// register the count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (en) begin
			cnt_r <= cnt_nxt;
		end
	end

	assign expired = (cnt_r == '0);
endmodule
`default_nettype wire

// *** rtl/flash_host.sv ***
`default_nettype none
// How it works
// - every write not refused by the sector guard puts a command word on the bus; reads are plain array reads with no command.
// - a confused device is brought back by pulling the reset pin low.
// - writes use CE and WE low with OE high; idle is both strobes high.
// - a read holds a valid address with CE and OE low and WE high.
module flash_host (
	input wire logic CLK_SYS, // system clock, 25 MHz
	input wire logic RST_N, // sync reset, active low
	input wire logic CLK_EN, // freezes all state while low
	input wire logic REQ_VALID, // user request present
	input wire logic REQ_WRITE, // 1 write, 0 read
	input wire logic [flash_host_pkg::ADDR_W-1:0] REQ_ADDR, // word address
	input wire logic REQ_BYTE_LSB, // byte select A-1 in byte mode
	input wire logic [flash_host_pkg::DATA_W-1:0] REQ_WDATA, // write data
	input wire logic BYTE_MODE, // 1 selects byte configuration
	input wire logic PROTECT_EN, // guard the outermost sector
	input wire logic FLASH_RESET_REQ, // pulse the device reset pin
	output logic REQ_READY, // request taken when valid and ready with FLASH_RESET_REQ low
	output logic RSP_VALID, // one-cycle answer strobe
	output logic [flash_host_pkg::DATA_W-1:0] RSP_DATA, // read data
	output logic RSP_REFUSED, // request refused, nothing driven
	output logic [flash_host_pkg::ADDR_W-1:0] FLASH_A, // address pins
	input wire logic [flash_host_pkg::DATA_W-1:0] DQ_IN, // data pins in
	output logic [flash_host_pkg::DATA_W-1:0] DQ_OUT, // data pins out
	output logic [flash_host_pkg::DATA_W-1:0] DQ_OE, // data drive enables
	output logic CE_N, // chip enable, active low
	output logic OE_N, // output enable, active low
	output logic WE_N, // write enable, active low
	output logic FLASH_RESET_N, // device reset, active low
	output logic FLASH_BYTE_N, // width select, low for byte mode
	output logic WRITE_PROTECT_ACCEL_N // outermost sector guard, active low
);
	import flash_host_pkg::*;

	state_t state_r, state_nxt;
	logic [ADDR_W-1:0] a_r, a_nxt;
	logic [DATA_W-1:0] dq_out_r, dq_out_nxt;
	logic [DATA_W-1:0] dq_oe_r, dq_oe_nxt;
	logic ce_n_r, ce_n_nxt;
	logic oe_n_r, oe_n_nxt;
	logic we_n_r, we_n_nxt;
	logic rst_pin_n_r, rst_pin_n_nxt;
	logic byte_n_r, byte_n_nxt;
	logic wp_n_r, wp_n_nxt;
	logic ready_r, ready_nxt;
	logic rsp_valid_r, rsp_valid_nxt;
	logic [DATA_W-1:0] rsp_data_r, rsp_data_nxt;
	logic refused_r, refused_nxt;
	logic write_r, write_nxt;
	logic [DATA_W-1:0] dq_s1_r;
	logic [DATA_W-1:0] dq_s2_r;
	logic tmr_load;
	logic [TMR_W-1:0] tmr_val;
	logic tmr_done;
	logic hits_guarded;

	cycle_timer u_timer (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.en(CLK_EN),
		.load(tmr_load),
		.value(tmr_val),
		.expired(tmr_done)
	);

	// write to the last sector while PROTECT_EN is high, decoded from the input, not the registered guard pin
	assign hits_guarded = REQ_WRITE && PROTECT_EN &&
		(REQ_ADDR[ADDR_W-1:SECTOR_OFS_W] == LAST_SECTOR);

	// data pins from the device pass two flip-flops first
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			dq_s1_r <= '0;
			dq_s2_r <= '0;
		end else if (CLK_EN) begin
			dq_s1_r <= DQ_IN;
			dq_s2_r <= dq_s1_r;
		end
	end

	// bus sequencer: next values
	always_comb begin
		state_nxt = state_r;
		a_nxt = a_r;
		dq_out_nxt = dq_out_r;
		dq_oe_nxt = dq_oe_r;
		ce_n_nxt = ce_n_r;
		oe_n_nxt = oe_n_r;
		we_n_nxt = we_n_r;
		rst_pin_n_nxt = rst_pin_n_r;
		byte_n_nxt = byte_n_r;
		wp_n_nxt = wp_n_r;
		ready_nxt = ready_r;
		rsp_valid_nxt = 1'b0;
		rsp_data_nxt = rsp_data_r;
		refused_nxt = refused_r;
		write_nxt = write_r;
		tmr_load = 1'b0;
		tmr_val = '0;
		case (state_r)
			ST_BOOT: begin
				// every start goes through a device reset pulse
				rst_pin_n_nxt = 1'b0;
				tmr_load = 1'b1;
				tmr_val = RESET_PULSE_CYC;
				state_nxt = ST_RESET_PULSE;
			end
			ST_RESET_PULSE: begin
				if (tmr_done) begin
					rst_pin_n_nxt = 1'b1;
					tmr_load = 1'b1;
					tmr_val = RESET_RECOVER_CYC;
					state_nxt = ST_RESET_WAIT;
				end
			end
			ST_RESET_WAIT: begin
				// device is back in array read, no command needed
				if (tmr_done) begin
					ready_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				wp_n_nxt = ~PROTECT_EN;
				byte_n_nxt = ~BYTE_MODE;
				if (FLASH_RESET_REQ) begin
					ready_nxt = 1'b0;
					rst_pin_n_nxt = 1'b0;
					tmr_load = 1'b1;
					tmr_val = RESET_PULSE_CYC;
					state_nxt = ST_RESET_PULSE;
				end else if (REQ_VALID && hits_guarded) begin
					rsp_valid_nxt = 1'b1;
					refused_nxt = 1'b1;
				end else if (REQ_VALID) begin
					// address settles while CE is still high
					ready_nxt = 1'b0;
					refused_nxt = 1'b0;
					write_nxt = REQ_WRITE;
					a_nxt = REQ_ADDR;
					if (BYTE_MODE) begin
						dq_out_nxt = {REQ_BYTE_LSB, 7'h00, REQ_WDATA[7:0]};
						dq_oe_nxt = REQ_WRITE ? OE_BYTE_WR : OE_BYTE_RD;
					end else begin
						dq_out_nxt = REQ_WDATA;
						dq_oe_nxt = REQ_WRITE ? OE_WORD : OE_NONE;
					end
					state_nxt = ST_SETUP;
				end
			end
			ST_SETUP: begin
				ce_n_nxt = 1'b0;
				if (write_r) begin
					we_n_nxt = 1'b0;
					oe_n_nxt = 1'b1;
					tmr_load = 1'b1;
					tmr_val = WE_PULSE_CYC;
					state_nxt = ST_WR_PULSE;
				end else begin
					oe_n_nxt = 1'b0;
					we_n_nxt = 1'b1;
					tmr_load = 1'b1;
					tmr_val = READ_WAIT_CYC;
					state_nxt = ST_READ;
				end
			end
			ST_READ: begin
				// wait covers both access times and the synchroniser
				if (tmr_done) begin
					if (!byte_n_r) begin
						rsp_data_nxt = {8'h00, dq_s2_r[7:0]};
					end else begin
						rsp_data_nxt = dq_s2_r;
					end
					rsp_valid_nxt = 1'b1;
					ce_n_nxt = 1'b1;
					oe_n_nxt = 1'b1;
					dq_oe_nxt = OE_NONE;
					tmr_load = 1'b1;
					tmr_val = CE_GAP_CYC;
					state_nxt = ST_GAP;
				end
			end
			ST_WR_PULSE: begin
				// rising WE latches the command word
				if (tmr_done) begin
					we_n_nxt = 1'b1;
					tmr_load = 1'b1;
					tmr_val = WR_HOLD_CYC;
					state_nxt = ST_WR_HOLD;
				end
			end
			ST_WR_HOLD: begin
				if (tmr_done) begin
					ce_n_nxt = 1'b1;
					dq_oe_nxt = OE_NONE;
					rsp_valid_nxt = 1'b1;
					tmr_load = 1'b1;
					tmr_val = CE_GAP_CYC;
					state_nxt = ST_GAP;
				end
			end
			ST_GAP: begin
				// CE high long enough that the next fall latches anew
				if (tmr_done) begin
					ready_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_BOOT;
			end
		endcase
	end

	// bus sequencer: registers
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state_r <= ST_BOOT;
			a_r <= '0;
			dq_out_r <= '0;
			dq_oe_r <= OE_NONE;
			ce_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			we_n_r <= 1'b1;
			rst_pin_n_r <= 1'b0;
			byte_n_r <= 1'b1;
			wp_n_r <= 1'b1;
			ready_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_data_r <= '0;
			refused_r <= 1'b0;
			write_r <= 1'b0;
		end else if (CLK_EN) begin
			state_r <= state_nxt;
			a_r <= a_nxt;
			dq_out_r <= dq_out_nxt;
			dq_oe_r <= dq_oe_nxt;
			ce_n_r <= ce_n_nxt;
			oe_n_r <= oe_n_nxt;
			we_n_r <= we_n_nxt;
			rst_pin_n_r <= rst_pin_n_nxt;
			byte_n_r <= byte_n_nxt;
			wp_n_r <= wp_n_nxt;
			ready_r <= ready_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			rsp_data_r <= rsp_data_nxt;
			refused_r <= refused_nxt;
			write_r <= write_nxt;
		end
	end

	// outputs straight from flip-flops
	assign REQ_READY = ready_r;
	assign RSP_VALID = rsp_valid_r;
	assign RSP_DATA = rsp_data_r;
	assign RSP_REFUSED = refused_r;
	assign FLASH_A = a_r;
	assign DQ_OUT = dq_out_r;
	assign DQ_OE = dq_oe_r;
	assign CE_N = ce_n_r;
	assign OE_N = oe_n_r;
	assign WE_N = we_n_r;
	assign FLASH_RESET_N = rst_pin_n_r;
	assign FLASH_BYTE_N = byte_n_r;
	assign WRITE_PROTECT_ACCEL_N = wp_n_r;
endmodule
`default_nettype wire

// *** test/flash_model.sv ***
`default_nettype none
module flash_model (
	input wire logic [25:0] a, // address pins
	input wire logic ce_n, // chip enable
	input wire logic oe_n, // output enable
	input wire logic we_n, // write enable
	input wire logic rst_n, // device reset
	input wire logic byte_n, // width select
	input wire logic wp_n, // outermost sector guard
	input wire logic [15:0] dq, // resolved data lines
	output logic [15:0] q // device side of data lines
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [int];
	logic [26:0] la = '0;
	logic rd = 1'b0;
	logic [15:0] last = 16'h0000;
	logic [15:0] v;
	logic [15:0] val;
	logic [15:0] old;
	logic [25:0] wa;
	// unwritten words read back a fixed pattern of their address
	function automatic logic [15:0] word_at(input logic [25:0] w);
		return mem.exists(w) ? mem[w] : (w[15:0] ^ 16'hA5C3);
	endfunction
	// capture the whole address, A-1 from the top line
	always @(negedge ce_n) la = {a, dq[15]};
	// data only after the access time, one location per access
	always @(ce_n or oe_n or rst_n) begin
		rd = 1'b0;
		#100 rd = !ce_n && !oe_n && rst_n;
	end
	// word or byte lane; released lines show the inverse of last value
	always @* begin
		v = word_at(la[26:1]);
		val = byte_n ? v : {~last[15:8], la[0] ? v[15:8] : v[7:0]};
		q = rd ? val : ~last;
	end
	always @(negedge rd) last = val;
	// latched command write; open guard pin counts as high
	always @(posedge we_n) begin
		wa = la[26:1];
		old = word_at(wa);
		if (!ce_n && rst_n &&
			!(wp_n === 1'b0 && wa[25:16] == 10'h3FF)) begin
			if (byte_n)
				mem[wa] = dq;
			else if (la[0])
				mem[wa] = {dq[7:0], old[7:0]};
			else
				mem[wa] = {old[15:8], dq[7:0]};
		end
	end
endmodule
`default_nettype wire

// *** test/flash_host_chk.sv ***
`default_nettype none
module flash_host_chk (
	input wire logic CLK_SYS, // clock
	input wire logic RST_N, // reset
	input wire logic REQ_VALID, // request
	input wire logic REQ_WRITE, // write flag
	input wire logic [flash_host_pkg::ADDR_W-1:0] REQ_ADDR, // address
	input wire logic PROTECT_EN, // guard request
	input wire logic FLASH_RESET_REQ, // device reset request
	input wire logic REQ_READY, // idle
	input wire logic RSP_VALID, // answer
	input wire logic RSP_REFUSED, // refusal
	input wire logic [flash_host_pkg::ADDR_W-1:0] FLASH_A, // address pins
	input wire logic [flash_host_pkg::DATA_W-1:0] DQ_OE, // drive enables
	input wire logic CE_N, // chip enable
	input wire logic OE_N, // output enable
	input wire logic WE_N, // write enable
	input wire logic FLASH_RESET_N, // device reset
	input wire logic FLASH_BYTE_N, // width select
	input wire logic WRITE_PROTECT_ACCEL_N // guard pin
);
	timeunit 1ns;
	timeprecision 1ps;
	import flash_host_pkg::*;
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	// read strobes held through the wait, then answer
	sequence s_rd_hold;
		(!OE_N && !CE_N)[*6] ##1 (OE_N && CE_N && RSP_VALID);
	endsequence
	// write pulse with chip enable low
	sequence s_wr_low;
		(!WE_N && !CE_N)[*3];
	endsequence
	// release of write enable, then chip enable with the answer
	sequence s_wr_release;
		(WE_N && !CE_N)[*2] ##1 (CE_N && RSP_VALID);
	endsequence
	a_read_access_wait: assert property ($fell(OE_N) |-> s_rd_hold)
		else $error("read strobes or answer mistimed");
	a_write_pulse_seq: assert property (
		$fell(WE_N) |-> s_wr_low ##1 s_wr_release)
		else $error("write strobes mistimed");
	a_write_oe_high: assert property (!WE_N |-> !CE_N && OE_N)
		else $error("write without chip enable or with output enable");
	a_read_we_high: assert property (!OE_N |-> !CE_N && WE_N)
		else $error("read without chip enable or with write enable");
	a_addr_held_ce: assert property (
		!CE_N && !$past(CE_N) |-> $stable(FLASH_A))
		else $error("address moved while chip enabled");
	a_byte_mid_float: assert property (
		!FLASH_BYTE_N |-> DQ_OE[14:8] == 7'h00)
		else $error("middle data lines driven in byte mode");
	a_dev_reset_quiet: assert property (
		!FLASH_RESET_N |-> CE_N && WE_N && DQ_OE == 16'h0000)
		else $error("bus active during device reset");
	a_reset_req_pulse: assert property (
		REQ_READY && FLASH_RESET_REQ |=> !FLASH_RESET_N && !REQ_READY)
		else $error("device reset request not started");
	a_prot_pin_copy: assert property (
		REQ_READY && !FLASH_RESET_REQ |=>
		WRITE_PROTECT_ACCEL_N == !$past(PROTECT_EN))
		else $error("guard pin does not follow request");
	a_prot_refusal: assert property (
		REQ_READY && REQ_VALID && REQ_WRITE && PROTECT_EN &&
		!FLASH_RESET_REQ && REQ_ADDR[25:16] == 10'h3FF |=>
		RSP_VALID && RSP_REFUSED && CE_N && REQ_READY)
		else $error("guarded write not refused");
endmodule
bind flash_host flash_host_chk chk_u (
	.CLK_SYS, .RST_N, .REQ_VALID, .REQ_WRITE, .REQ_ADDR, .PROTECT_EN,
	.FLASH_RESET_REQ, .REQ_READY, .RSP_VALID, .RSP_REFUSED, .FLASH_A,
	.DQ_OE, .CE_N, .OE_N, .WE_N, .FLASH_RESET_N, .FLASH_BYTE_N,
	.WRITE_PROTECT_ACCEL_N
);
`default_nettype wire

// *** test/flash_host_test.sv ***
`default_nettype none
module flash_host_test;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_host_pkg::*;
	typedef struct packed {
		logic w;
		logic b;
		logic p;
		logic [ADDR_W-1:0] a;
		logic l;
		logic [DATA_W-1:0] d;
		logic [DATA_W-1:0] e;
	} row_t;
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	logic CLK_EN = 1'b1;
	logic REQ_VALID = 1'b0;
	logic REQ_WRITE = 1'b0;
	logic [ADDR_W-1:0] REQ_ADDR = '0;
	logic REQ_BYTE_LSB = 1'b0;
	logic [DATA_W-1:0] REQ_WDATA = 16'h0000;
	logic BYTE_MODE = 1'b0;
	logic PROTECT_EN = 1'b0;
	logic FLASH_RESET_REQ = 1'b0;
	logic REQ_READY, RSP_VALID, RSP_REFUSED, CE_N, OE_N, WE_N;
	logic FLASH_RESET_N, FLASH_BYTE_N, WRITE_PROTECT_ACCEL_N;
	logic [DATA_W-1:0] RSP_DATA, DQ_OUT, DQ_OE, dev_q;
	logic [ADDR_W-1:0] FLASH_A;
	wire logic [DATA_W-1:0] DQ_IN = (DQ_OE & DQ_OUT) | (~DQ_OE & dev_q);
	int n_errors = 0;
	int checks_done = 0;
	// writes expect no refusal, reads expect the data
	row_t rows [9] = '{
		'{1'b1, 1'b0, 1'b0, 26'h0001234, 1'b0, 16'hBEEF, 16'h0000},
		'{1'b0, 1'b0, 1'b0, 26'h3FFFFFF, 1'b0, 16'h0000, 16'h5A3C},
		'{1'b0, 1'b0, 1'b0, 26'h0001234, 1'b0, 16'h0000, 16'hBEEF},
		'{1'b1, 1'b1, 1'b0, 26'h0000010, 1'b1, 16'h005A, 16'h0000},
		'{1'b0, 1'b1, 1'b0, 26'h0000010, 1'b0, 16'h0000, 16'h00D3},
		'{1'b0, 1'b1, 1'b0, 26'h0000010, 1'b1, 16'h0000, 16'h005A},
		'{1'b0, 1'b0, 1'b0, 26'h0000010, 1'b0, 16'h0000, 16'h5AD3},
		'{1'b1, 1'b0, 1'b0, 26'h3FF0000, 1'b0, 16'h1357, 16'h0000},
		'{1'b0, 1'b0, 1'b0, 26'h3FF0000, 1'b0, 16'h0000, 16'h1357}};
	flash_host dut_u (
		.CLK_SYS, .RST_N, .CLK_EN, .REQ_VALID, .REQ_WRITE, .REQ_ADDR,
		.REQ_BYTE_LSB, .REQ_WDATA, .BYTE_MODE, .PROTECT_EN, .FLASH_RESET_REQ,
		.REQ_READY, .RSP_VALID, .RSP_DATA, .RSP_REFUSED, .FLASH_A, .DQ_IN,
		.DQ_OUT, .DQ_OE, .CE_N, .OE_N, .WE_N, .FLASH_RESET_N, .FLASH_BYTE_N,
		.WRITE_PROTECT_ACCEL_N
	);
	flash_model dev_u (
		.a(FLASH_A), .ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N),
		.rst_n(FLASH_RESET_N), .byte_n(FLASH_BYTE_N),
		.wp_n(WRITE_PROTECT_ACCEL_N), .dq(DQ_IN), .q(dev_q)
	);
	// clock of 40 ns
	always #20 CLK_SYS = ~CLK_SYS;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one request, waiting on ready and on the answer
	task automatic xfer(input row_t r);
		int n;
		n = 0;
		BYTE_MODE = r.b;
		PROTECT_EN = r.p;
		REQ_WRITE = r.w;
		REQ_ADDR = r.a;
		REQ_BYTE_LSB = r.l;
		REQ_WDATA = r.d;
		@(negedge CLK_SYS);
		while (REQ_READY !== 1'b1 && n < 100) begin
			@(negedge CLK_SYS);
			n++;
		end
		REQ_VALID = 1'b1;
		@(negedge CLK_SYS);
		REQ_VALID = 1'b0;
		while (RSP_VALID !== 1'b1 && n < 100) begin
			@(negedge CLK_SYS);
			n++;
		end
		chk(16'(n < 100), 16'h0001);
		chk(r.w ? 16'(RSP_REFUSED) : RSP_DATA, r.e);
	endtask
	// watchdog well beyond the expected run
	initial begin
		#(40 * 8000);
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (15) @(negedge CLK_SYS);
		chk(16'({REQ_READY, CE_N, FLASH_RESET_N}), 16'h0002);
		@(negedge CLK_SYS);
		RST_N = 1'b1;
		foreach (rows[i]) begin
			xfer(rows[i]);
			$display("row %0d done", i);
		end
		xfer('{1'b1, 1'b0, 1'b1, 26'h3FF0001, 1'b0, 16'h2468, 16'h0001});
		xfer('{1'b0, 1'b0, 1'b0, 26'h3FF0001, 1'b0, 16'h0000, 16'hA5C2});
		// guard covers only the outermost sector
		xfer('{1'b1, 1'b0, 1'b1, 26'h3FE0020, 1'b0, 16'h1111, 16'h0000});
		xfer('{1'b0, 1'b0, 1'b1, 26'h3FE0020, 1'b0, 16'h0000, 16'h1111});
		$display("guarded write done");
		repeat (3) @(negedge CLK_SYS);
		FLASH_RESET_REQ = 1'b1;
		@(negedge CLK_SYS);
		FLASH_RESET_REQ = 1'b0;
		chk(16'({FLASH_RESET_N, REQ_READY}), 16'h0000);
		xfer('{1'b0, 1'b0, 1'b0, 26'h0001234, 1'b0, 16'h0000, 16'hBEEF});
		$display("device reset done");
		RST_N = 1'b0;
		@(negedge CLK_SYS);
		chk(16'({REQ_READY, CE_N, FLASH_RESET_N}), 16'h0002);
		RST_N = 1'b1;
		xfer('{1'b0, 1'b1, 1'b0, 26'h0000010, 1'b1, 16'h0000, 16'h005A});
		$display("host reset done");
		// clock enable low freezes the width-select copy
		repeat (3) @(negedge CLK_SYS);
		CLK_EN = 1'b0;
		BYTE_MODE = 1'b0;
		repeat (3) @(negedge CLK_SYS);
		chk(16'({FLASH_BYTE_N, REQ_READY}), 16'h0001);
		CLK_EN = 1'b1;
		@(negedge CLK_SYS);
		chk(16'({FLASH_BYTE_N, REQ_READY}), 16'h0003);
		$display("clock enable freeze done");
		print_verdict();
	end
endmodule
`default_nettype wire
